// file: rtl/rpms_pkg.sv
// constants shared by the reset pin and mode select ends
package rpms_pkg;
  // ****************************************
  // timing counts: reset in bus clock cycles, bit timing in ticks of BDC_DIV bus clock cycles
  // ****************************************
  localparam int RST_DRIVE_CYC = 66;
  localparam int RST_SETTLE_CYC = 4;
  localparam int BDC_DIV = 4;
  localparam int BIT_TICKS = 16;
  localparam int LOW_ONE_TICKS = 4;
  localparam int LOW_ZERO_TICKS = 13;
  localparam int SAMPLE_TICK = 8;
  // ****************************************
  // device register map
  // ****************************************
  localparam logic [2:0] DEV_OPT_ADDR = 3'h0;
  localparam logic [2:0] DEV_CAUSE_ADDR = 3'h1;
  localparam logic [2:0] DEV_FORCE_ADDR = 3'h2;
  localparam int OPT_DBG_EN_BIT = 7;
  localparam int OPT_RST_EN_BIT = 6;
  localparam int OPT_CMP_SEL_BIT = 5;
  localparam int OPT_EXT_CLK_BIT = 0;
  localparam int CAUSE_POR_BIT = 7;
  localparam int CAUSE_PIN_BIT = 6;
  localparam int CAUSE_SRC_LSB = 2;
  localparam int CAUSE_DBG_BIT = 1;
  localparam int FORCE_BIT = 0;
  localparam logic [7:0] CAUSE_POR_VAL = 8'h80;
  // command byte arbitrary
  localparam logic [7:0] CMD_FORCE_RST = 8'h5a;
  // ****************************************
  // host register map
  // ****************************************
  localparam logic [1:0] HOST_CTRL_ADDR = 2'h0;
  localparam logic [1:0] HOST_TX_ADDR = 2'h1;
  localparam logic [1:0] HOST_STAT_ADDR = 2'h2;
  localparam int CTRL_RST_LOW_BIT = 0;
  localparam int CTRL_MS_LOW_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RST_LVL_BIT = 1;
  localparam int STAT_DBG_LVL_BIT = 2;
endpackage : rpms_pkg

// file: rtl/rpms_link_if.sv
// shared reset pin and debug pin between device and debug host
`timescale 1ns/100ps
interface rpms_link_if;
  logic rst_dev_oe;
  logic rst_dev_out;
  logic rst_pu;
  logic rst_host_oe;
  logic dbg_dev_oe;
  logic dbg_dev_out;
  logic dbg_pu;
  logic dbg_host_oe;
  logic dbg_host_out;
  logic rst_level;
  logic dbg_level;
  // ****************************************
  // wire levels
  // ****************************************
  // host only pulls the reset pin low but drives the debug pin both ways; device out drives either level on both pins while its oe is set
  assign rst_level = rst_host_oe ? 1'b0 :
                     (rst_dev_oe ? rst_dev_out : 1'b1);
  assign dbg_level = dbg_host_oe ? dbg_host_out :
                     (dbg_dev_oe ? dbg_dev_out : 1'b1);
  modport dev (
    output rst_dev_oe, rst_dev_out, rst_pu, dbg_dev_oe, dbg_dev_out,
    output dbg_pu,
    input rst_level, dbg_level
  );
  modport host (
    output rst_host_oe, dbg_host_oe, dbg_host_out,
    input rst_level, dbg_level
  );
endinterface : rpms_link_if

// file: rtl/rpms_bit_tx.sv
// one-wire background bit transmitter
`timescale 1ns/100ps
module rpms_bit_tx (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy_ff,
  output logic oe_ff,
  output logic out_ff
);
  logic [7:0] sh_ff;
  logic [3:0] tk_ff;
  logic [2:0] bit_ff;
  logic [3:0] low_end;

  assign low_end = sh_ff[7] ? 4'(rpms_pkg::LOW_ONE_TICKS) :
                              4'(rpms_pkg::LOW_ZERO_TICKS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      sh_ff <= 8'h00;
      tk_ff <= 4'h0;
      bit_ff <= 3'h0;
    end else if (!busy_ff) begin
      if (start) begin
        busy_ff <= 1'b1;
        sh_ff <= data;
        tk_ff <= 4'h0;
        bit_ff <= 3'h0;
      end
    end else if (tick) begin
      if (tk_ff == 4'(rpms_pkg::BIT_TICKS - 1)) begin
        tk_ff <= 4'h0;
        sh_ff <= {sh_ff[6:0], 1'b0};
        bit_ff <= bit_ff + 3'h1;
        if (bit_ff == 3'h7) begin
          busy_ff <= 1'b0;
        end
      end else begin
        tk_ff <= tk_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_ff <= 1'b0;
      out_ff <= 1'b0;
    end else if (!busy_ff) begin
      oe_ff <= 1'b0;
      out_ff <= 1'b0;
    end else if (tick) begin
      oe_ff <= (tk_ff <= low_end);
      out_ff <= (tk_ff == low_end);
    end
  end
endmodule : rpms_bit_tx

// file: rtl/rpms_host.sv
// debug pod end: external reset, mode select hold, command bytes
`timescale 1ns/100ps
module rpms_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  rpms_link_if.host link
);
  logic [7:0] ctrl_ff;
  logic [$clog2(rpms_pkg::BDC_DIV)-1:0] div_ff;
  logic tick;
  logic start;
  logic tx_busy;
  logic tx_oe;
  logic tx_out;
  logic ms_hold;
  logic ms_rel;

  assign tick = (div_ff == '0);
  assign start = reg_wr && reg_addr == rpms_pkg::HOST_TX_ADDR;
  assign ms_hold = ctrl_ff[rpms_pkg::CTRL_MS_LOW_BIT];
  assign ms_rel = !ms_hold && link.dbg_host_oe && !link.dbg_host_out;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
    end else if (div_ff == ($clog2(rpms_pkg::BDC_DIV))'(rpms_pkg::BDC_DIV-1))
    begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  rpms_bit_tx u_tx (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .start(start),
    .data(reg_wdata),
    .busy_ff(tx_busy),
    .oe_ff(tx_oe),
    .out_ff(tx_out)
  );

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= 8'h00;
    end else if (reg_wr && reg_addr == rpms_pkg::HOST_CTRL_ADDR) begin
      ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd && reg_addr == rpms_pkg::HOST_CTRL_ADDR) begin
      reg_rdata_ff <= ctrl_ff;
    end else if (reg_rd && reg_addr == rpms_pkg::HOST_STAT_ADDR) begin
      reg_rdata_ff <= 8'h00;
      reg_rdata_ff[rpms_pkg::STAT_BUSY_BIT] <= tx_busy;
      reg_rdata_ff[rpms_pkg::STAT_RST_LVL_BIT] <= link.rst_level;
      reg_rdata_ff[rpms_pkg::STAT_DBG_LVL_BIT] <= link.dbg_level;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.rst_host_oe <= 1'b0;
      link.dbg_host_oe <= 1'b0;
      link.dbg_host_out <= 1'b0;
    end else begin
      link.rst_host_oe <= ctrl_ff[rpms_pkg::CTRL_RST_LOW_BIT];
      if (tx_busy) begin
        link.dbg_host_oe <= tx_oe;
        link.dbg_host_out <= tx_out;
      end else begin
        link.dbg_host_oe <= ms_hold || ms_rel;
        link.dbg_host_out <= ms_rel;
      end
    end
  end
endmodule : rpms_host

// file: rtl/rpms_dev.sv
// device end: reset pin, reset cause, mode select, debug pin
`timescale 1ns/100ps
module rpms_dev #(
  parameter int NSRC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NSRC-1:0] int_rst_req,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  input wire logic port_a5_out,
  input wire logic port_a5_oe,
  input wire logic port_a4_out,
  input wire logic port_a4_oe,
  input wire logic comparator_output,
  output logic port_a5_in_ff,
  output logic port_a4_in_ff,
  output logic sys_rst_ff,
  output logic bdm_ff,
  output logic use_int_clk_ff,
  output logic [7:0] rx_cmd_ff,
  output logic rx_cmd_vld_ff,
  rpms_link_if.dev link
);
  if (NSRC < 1 || NSRC > 4) begin : g_chk
    $error("rpms_dev: NSRC must be 1 to 4");
  end

  typedef enum logic [2:0] {
    S_RUN = 3'b001,
    S_DRIVE = 3'b010,
    S_WAIT = 3'b100
  } rpms_state_t;

  rpms_state_t st_ff;
  logic [6:0] cnt_ff;
  logic ms_ff;
  logic drive_ff;
  logic reset_pin_enable_bit_ff;
  logic dbg_en_ff;
  logic cmp_sel_ff;
  logic [7:0] cause_ff;
  logic [7:0] nxt_cause;
  logic ext_req;
  logic int_req;
  logic dbg_req;
  logic go;
  logic [$clog2(rpms_pkg::BDC_DIV)-1:0] div_ff;
  logic tick;
  logic prev_ff;
  logic rx_act_ff;
  logic [3:0] rx_tk_ff;
  logic [7:0] rx_sh_ff;
  logic [2:0] rx_cnt_ff;
  logic rx_en;
  logic wr_opt;

  // ****************************************
  // reset requests
  // ****************************************
  // external pin reset
  assign ext_req = reset_pin_enable_bit_ff && !link.rst_level;
  assign int_req = |int_rst_req;
  assign dbg_req = (reg_wr && reg_addr == rpms_pkg::DEV_FORCE_ADDR &&
                    reg_wdata[rpms_pkg::FORCE_BIT]) ||
                   (rx_cmd_vld_ff && rx_cmd_ff == rpms_pkg::CMD_FORCE_RST);
  assign go = (st_ff == S_RUN) && (ext_req || int_req || dbg_req);
  assign wr_opt = reg_wr && !sys_rst_ff &&
                  reg_addr == rpms_pkg::DEV_OPT_ADDR;

  always_comb begin
    nxt_cause = 8'h00;
    nxt_cause[rpms_pkg::CAUSE_PIN_BIT] = ext_req;
    nxt_cause[rpms_pkg::CAUSE_DBG_BIT] = dbg_req;
    nxt_cause[rpms_pkg::CAUSE_SRC_LSB +: NSRC] = int_rst_req;
  end

  // ****************************************
  // reset sequencer
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= S_WAIT;
      cnt_ff <= 7'h00;
      sys_rst_ff <= 1'b1;
      bdm_ff <= 1'b0;
      ms_ff <= 1'b1;
      drive_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        S_RUN: begin
          if (go) begin
            st_ff <= S_DRIVE;
            cnt_ff <= 7'h00;
            sys_rst_ff <= 1'b1;
            bdm_ff <= 1'b0;
            ms_ff <= dbg_req;
            drive_ff <= reset_pin_enable_bit_ff;
          end
        end
        S_DRIVE: begin
          if (cnt_ff == 7'(rpms_pkg::RST_DRIVE_CYC - 1)) begin
            st_ff <= S_WAIT;
            cnt_ff <= 7'h00;
            drive_ff <= 1'b0;
          end else begin
            cnt_ff <= cnt_ff + 7'h01;
          end
        end
        S_WAIT: begin
          if (reset_pin_enable_bit_ff && !link.rst_level) begin
            cnt_ff <= 7'h00;
          end else if (cnt_ff == 7'(rpms_pkg::RST_SETTLE_CYC - 1)) begin
            st_ff <= S_RUN;
            cnt_ff <= 7'h00;
            sys_rst_ff <= 1'b0;
            bdm_ff <= ms_ff && !link.dbg_level;
          end else begin
            cnt_ff <= cnt_ff + 7'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_ff <= rpms_pkg::CAUSE_POR_VAL;
    end else if (go) begin
      cause_ff <= nxt_cause;
    end
  end

  // ****************************************
  // option bits
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_enable_bit_ff <= 1'b0;
    end else if (wr_opt && reg_wdata[rpms_pkg::OPT_RST_EN_BIT]) begin
      reset_pin_enable_bit_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbg_en_ff <= 1'b1;
      cmp_sel_ff <= 1'b0;
      use_int_clk_ff <= 1'b1;
    end else if (go) begin
      dbg_en_ff <= 1'b1;
      cmp_sel_ff <= 1'b0;
      use_int_clk_ff <= 1'b1;
    end else if (wr_opt) begin
      dbg_en_ff <= reg_wdata[rpms_pkg::OPT_DBG_EN_BIT];
      cmp_sel_ff <= reg_wdata[rpms_pkg::OPT_CMP_SEL_BIT];
      use_int_clk_ff <= !reg_wdata[rpms_pkg::OPT_EXT_CLK_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd && reg_addr == rpms_pkg::DEV_OPT_ADDR) begin
      reg_rdata_ff <= 8'h00;
      reg_rdata_ff[rpms_pkg::OPT_DBG_EN_BIT] <= dbg_en_ff;
      reg_rdata_ff[rpms_pkg::OPT_RST_EN_BIT] <= reset_pin_enable_bit_ff;
      reg_rdata_ff[rpms_pkg::OPT_CMP_SEL_BIT] <= cmp_sel_ff;
      reg_rdata_ff[rpms_pkg::OPT_EXT_CLK_BIT] <= !use_int_clk_ff;
    end else if (reg_rd && reg_addr == rpms_pkg::DEV_CAUSE_ADDR) begin
      reg_rdata_ff <= cause_ff;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // ****************************************
  // pin control
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.rst_dev_oe <= 1'b0;
      link.rst_dev_out <= 1'b0;
      link.rst_pu <= 1'b0;
    end else if (reset_pin_enable_bit_ff) begin
      link.rst_dev_oe <= drive_ff;
      link.rst_dev_out <= 1'b0;
      link.rst_pu <= 1'b1;
    end else begin
      link.rst_dev_oe <= port_a5_oe;
      link.rst_dev_out <= port_a5_out;
      link.rst_pu <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.dbg_dev_oe <= 1'b0;
      link.dbg_dev_out <= 1'b0;
      link.dbg_pu <= 1'b1;
    end else begin
      link.dbg_dev_oe <= !dbg_en_ff && (cmp_sel_ff || port_a4_oe);
      link.dbg_dev_out <= cmp_sel_ff ? comparator_output : port_a4_out;
      link.dbg_pu <= dbg_en_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_a5_in_ff <= 1'b1;
      port_a4_in_ff <= 1'b1;
    end else begin
      port_a5_in_ff <= link.rst_level;
      port_a4_in_ff <= link.dbg_level;
    end
  end

  // ****************************************
  // debug receiver
  // ****************************************
  assign tick = (div_ff == '0);
  assign rx_en = dbg_en_ff && !sys_rst_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
    end else if (div_ff == ($clog2(rpms_pkg::BDC_DIV))'(rpms_pkg::BDC_DIV-1))
    begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b1;
      rx_act_ff <= 1'b0;
      rx_tk_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_cmd_ff <= 8'h00;
      rx_cmd_vld_ff <= 1'b0;
    end else begin
      prev_ff <= link.dbg_level;
      rx_cmd_vld_ff <= 1'b0;
      if (!rx_en) begin
        rx_act_ff <= 1'b0;
        rx_cnt_ff <= 3'h0;
      end else if (!rx_act_ff) begin
        if (prev_ff && !link.dbg_level) begin
          rx_act_ff <= 1'b1;
          rx_tk_ff <= 4'h0;
        end
      end else if (tick) begin
        if (rx_tk_ff == 4'(rpms_pkg::SAMPLE_TICK - 1)) begin
          rx_act_ff <= 1'b0;
          rx_sh_ff <= {rx_sh_ff[6:0], link.dbg_level};
          rx_cnt_ff <= rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == 3'h7) begin
            rx_cmd_ff <= {rx_sh_ff[6:0], link.dbg_level};
            rx_cmd_vld_ff <= 1'b1;
          end
        end else begin
          rx_tk_ff <= rx_tk_ff + 4'h1;
        end
      end
    end
  end
endmodule : rpms_dev

// file: tb/rpms_chk.sv
// assertions on the shared reset and debug pins
`timescale 1ns/100ps
module rpms_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_dev_oe,
  input wire logic rst_dev_out,
  input wire logic rst_pu,
  input wire logic rst_level,
  input wire logic dbg_pu,
  input wire logic dbg_host_oe,
  input wire logic dbg_host_out,
  input wire logic dbg_level,
  input wire logic sys_rst_ff,
  input wire logic bdm_ff,
  input wire logic use_int_clk_ff
);
  // ********
  // helpers
  // ********
  logic [7:0] drv_cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_cnt_ff <= 8'h00;
    end else if (rst_dev_oe && rst_pu) begin
      drv_cnt_ff <= drv_cnt_ff + 8'h01;
    end else begin
      drv_cnt_ff <= 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_drive_low;
    rst_dev_oe && !rst_dev_out;
  endsequence
  sequence s_speedup_gone;
    ##[1:4] !(dbg_host_oe && dbg_host_out);
  endsequence
  // ********
  // assertions
  // ********
  AST_RST_HOLD: assert property (
    $rose(rst_dev_oe) && rst_pu |-> s_drive_low [*8])
    else $error("reset pin not held low");
  AST_RST_COUNT: assert property (
    $fell(rst_dev_oe) && $past(rst_pu) |->
    drv_cnt_ff == 8'(rpms_pkg::RST_DRIVE_CYC))
    else $error("reset pin low time wrong");
  AST_RST_CAUSE: assert property (
    $rose(rst_dev_oe) && rst_pu |-> $past(sys_rst_ff))
    else $error("reset pin driven outside reset");
  AST_OPEN_DRAIN: assert property (
    rst_pu |-> !(rst_dev_oe && rst_dev_out))
    else $error("reset pin driven high");
  AST_PIN_RESET: assert property (
    !sys_rst_ff && rst_pu && !rst_level |=> sys_rst_ff)
    else $error("low reset pin ignored");
  AST_SETTLE: assert property (
    $fell(sys_rst_ff) |-> $past(rst_level) && $past(rst_level, 4))
    else $error("reset released while pin low");
  AST_NORMAL: assert property (
    $fell(sys_rst_ff) && $past(dbg_level) |-> !bdm_ff)
    else $error("background mode with high mode pin");
  AST_DBG_PU: assert property (
    $rose(sys_rst_ff) |-> ##[0:2] dbg_pu)
    else $error("debug pull-up not restored");
  AST_INT_CLK: assert property (
    $rose(sys_rst_ff) |-> ##[0:1] use_int_clk_ff)
    else $error("reset kept external clock");
  AST_SPEEDUP: assert property (
    $rose(dbg_host_oe && dbg_host_out) |-> s_speedup_gone)
    else $error("speedup pulse too long");
  AST_SPEEDUP_END: assert property (
    $fell(dbg_host_oe) |-> $past(dbg_host_out))
    else $error("line released without speedup");
endmodule : rpms_chk

// file: tb/rpms_bench.sv
// bench joining device and debug host ends
`timescale 1ns/100ps
module rpms_bench;
  logic clk = 1'b0, rst = 1'b1;
  logic [3:0] int_rst_req = 4'h0;
  logic [2:0] d_addr = 3'h0;
  logic [1:0] h_addr = 2'h0;
  logic [7:0] d_wdata = 8'h00, h_wdata = 8'h00, d_rdata, h_rdata, got, hi;
  logic d_wr = 1'b0, d_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0;
  logic p5o = 1'b0, p5e = 1'b0, p4o = 1'b0, p4e = 1'b0, cmpo = 1'b0;
  logic p5i, p4i, sys_rst_ff, bdm_ff, int_clk, rx_vld;
  logic [7:0] rx_cmd;
  int mismatches = 0, tests_run = 0, cyc = 0;
  rpms_link_if rpms_link_if_inst ();
  rpms_dev rpms_dev_inst (.clk(clk), .rst(rst), .int_rst_req(int_rst_req),
    .reg_addr(d_addr), .reg_wdata(d_wdata), .reg_wr(d_wr), .reg_rd(d_rd),
    .reg_rdata_ff(d_rdata), .port_a5_out(p5o), .port_a5_oe(p5e),
    .port_a4_out(p4o), .port_a4_oe(p4e), .comparator_output(cmpo),
    .port_a5_in_ff(p5i), .port_a4_in_ff(p4i), .sys_rst_ff(sys_rst_ff),
    .bdm_ff(bdm_ff), .use_int_clk_ff(int_clk), .rx_cmd_ff(rx_cmd),
    .rx_cmd_vld_ff(rx_vld), .link(rpms_link_if_inst));
  rpms_host rpms_host_inst (.clk(clk), .rst(rst), .reg_addr(h_addr),
    .reg_wdata(h_wdata), .reg_wr(h_wr), .reg_rd(h_rd),
    .reg_rdata_ff(h_rdata), .link(rpms_link_if_inst));
  rpms_chk rpms_chk_inst (.clk(clk), .rst(rst),
    .rst_dev_oe(rpms_link_if_inst.rst_dev_oe),
    .rst_dev_out(rpms_link_if_inst.rst_dev_out),
    .rst_pu(rpms_link_if_inst.rst_pu),
    .rst_level(rpms_link_if_inst.rst_level),
    .dbg_pu(rpms_link_if_inst.dbg_pu),
    .dbg_host_oe(rpms_link_if_inst.dbg_host_oe),
    .dbg_host_out(rpms_link_if_inst.dbg_host_out),
    .dbg_level(rpms_link_if_inst.dbg_level), .sys_rst_ff(sys_rst_ff),
    .bdm_ff(bdm_ff), .use_int_clk_ff(int_clk));
  // ********
  // clock, timeout, tasks
  // ********
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: byte got %h exp %h", $time, g, e);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: bit got %b exp %b", $time, g, e);
    end
  endtask : cmp_bit
  task automatic dev_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    d_addr <= a;
    d_wdata <= d;
    d_wr <= 1'b1;
    @(posedge clk);
    d_wr <= 1'b0;
  endtask : dev_wr
  task automatic dev_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    d_addr <= a;
    d_rd <= 1'b1;
    @(posedge clk);
    d_rd <= 1'b0;
    #1;
    d = d_rdata;
  endtask : dev_rd
  task automatic host_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge clk);
    h_wr <= 1'b0;
  endtask : host_wr
  task automatic host_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge clk);
    h_rd <= 1'b0;
    #1;
    d = h_rdata;
  endtask : host_rd
  task automatic wait_run(output logic [7:0] n);
    int i;
    n = 8'h00;
    for (i = 0; i < 800 && sys_rst_ff !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    for (i = 0; i < 400 && sys_rst_ff !== 1'b0; i++) begin
      if (rpms_link_if_inst.rst_dev_oe === 1'b1) n = n + 8'h01;
      @(posedge clk);
      #1;
    end
    cmp_bit(sys_rst_ff, 1'b0);
  endtask : wait_run
  task automatic wait_rx;
    int i;
    for (i = 0; i < 800 && rx_vld !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_rx
  // ********
  // tests
  // ********
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_run(hi);
    cmp_byte(hi, 8'h00);
    dev_rd(rpms_pkg::DEV_CAUSE_ADDR, got);
    cmp_byte(got, rpms_pkg::CAUSE_POR_VAL);
    dev_rd(rpms_pkg::DEV_OPT_ADDR, got);
    cmp_byte(got, 8'h80);
    dev_rd(3'h5, got);
    cmp_byte(got, 8'h00);
    cmp_bit(bdm_ff, 1'b0);
    cmp_bit(int_clk, 1'b1);
    cmp_bit(rpms_link_if_inst.dbg_pu, 1'b1);
    host_wr(rpms_pkg::HOST_CTRL_ADDR, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    cmp_bit(sys_rst_ff, 1'b0);
    cmp_bit(p5i, 1'b0);
    host_wr(rpms_pkg::HOST_CTRL_ADDR, 8'h00);
    dev_wr(rpms_pkg::DEV_OPT_ADDR, 8'hc0);
    dev_rd(rpms_pkg::DEV_OPT_ADDR, got);
    cmp_byte(got, 8'hc0);
    @(posedge clk);
    int_rst_req <= 4'h2;
    @(posedge clk);
    int_rst_req <= 4'h0;
    wait_run(hi);
    cmp_byte(hi, 8'(rpms_pkg::RST_DRIVE_CYC));
    dev_rd(rpms_pkg::DEV_CAUSE_ADDR, got);
    cmp_byte(got, 8'h1 << (rpms_pkg::CAUSE_SRC_LSB + 1));
    dev_wr(rpms_pkg::DEV_OPT_ADDR, 8'h00);
    dev_rd(rpms_pkg::DEV_OPT_ADDR, got);
    cmp_byte(got, 8'h40);
    cmp_bit(rpms_link_if_inst.dbg_pu, 1'b0);
    dev_wr(rpms_pkg::DEV_OPT_ADDR, 8'h21);
    repeat (2) @(posedge clk);
    #1;
    cmp_bit(int_clk, 1'b0);
    cmp_bit(p4i, 1'b0);
    host_wr(rpms_pkg::HOST_CTRL_ADDR, 8'h03);
    host_wr(rpms_pkg::HOST_CTRL_ADDR, 8'h02);
    wait_run(hi);
    cmp_byte(hi, 8'(rpms_pkg::RST_DRIVE_CYC));
    cmp_bit(bdm_ff, 1'b0);
    dev_rd(rpms_pkg::DEV_CAUSE_ADDR, got);
    cmp_byte(got, 8'h40);
    dev_rd(rpms_pkg::DEV_OPT_ADDR, got);
    cmp_byte(got, 8'hc0);
    cmp_bit(int_clk, 1'b1);
    dev_wr(rpms_pkg::DEV_FORCE_ADDR, 8'h01);
    wait_run(hi);
    cmp_bit(bdm_ff, 1'b1);
    dev_rd(rpms_pkg::DEV_CAUSE_ADDR, got);
    cmp_byte(got, 8'h02);
    host_wr(rpms_pkg::HOST_CTRL_ADDR, 8'h00);
    repeat (4) @(posedge clk);
    host_wr(rpms_pkg::HOST_TX_ADDR, 8'ha3);
    host_rd(rpms_pkg::HOST_STAT_ADDR, got);
    cmp_bit(got[rpms_pkg::STAT_BUSY_BIT], 1'b1);
    wait_rx();
    cmp_bit(rx_vld, 1'b1);
    cmp_byte(rx_cmd, 8'ha3);
    got = 8'h01;
    for (int i = 0; i < 100 && got[rpms_pkg::STAT_BUSY_BIT] !== 1'b0;
         i++) begin
      host_rd(rpms_pkg::HOST_STAT_ADDR, got);
    end
    cmp_byte(got, 8'h06);
    host_wr(rpms_pkg::HOST_TX_ADDR, rpms_pkg::CMD_FORCE_RST);
    wait_run(hi);
    cmp_byte(hi, 8'(rpms_pkg::RST_DRIVE_CYC));
    cmp_bit(bdm_ff, 1'b0);
    dev_rd(rpms_pkg::DEV_CAUSE_ADDR, got);
    cmp_byte(got, 8'h02);
    conclude();
  end
endmodule : rpms_bench
